// [core/prm_map.vh]
`ifndef PRM_MAP_VH
`define PRM_MAP_VH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define PRM_OFS_ROUTE_PRI 8'h00
`define PRM_OFS_ROUTE_SEC 8'h04
`define PRM_OFS_BLOCK_CFG 8'h08
`define PRM_OFS_STATUS 8'h0c

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define PRM_RST_ROUTE_PRI 8'h55
`define PRM_RST_ROUTE_SEC 8'ha5
`define PRM_RST_BLOCK_CFG 8'h00

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define PRM_NUM_STAGES 4
`define PRM_STG_LOW_OC 0
`define PRM_STG_HIGH_OC 1
`define PRM_STG_LOW_EF 2
`define PRM_STG_HIGH_EF 3
`define PRM_BLK_FIELD_LSB 0
`define PRM_BLK_FIELD_MSB 3
`define PRM_ST_START_LSB 0
`define PRM_ST_TRIP_LSB 4
`define PRM_ST_BLOCK_IN 8
`define PRM_ST_OUT_LSB 9
`define PRM_ST_WIDTH 15

// ----------------------------------------------------------------
// bus encodings
// ----------------------------------------------------------------
`define PRM_HTRANS_NONSEQ 2'b10
`define PRM_HRESP_OKAY 1'b0
`define PRM_ADDR_BITS 8

`endif

// [core/prm_sync.v]
`timescale 1ns/1ps

// ----------------------------------------------------------------
// two-flop synchroniser for the pin inputs
// ----------------------------------------------------------------
module prm_sync (
    input wire hclk,
    input wire hresetn,
    input wire [8:0] async_in,
    output reg [8:0] sync_out
);

reg [8:0] meta_r;

// first stage feeds only the second stage
always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        meta_r <= 9'h000;
        sync_out <= 9'h000;
    end else begin
        meta_r <= async_in;
        sync_out <= meta_r;
    end
end

endmodule // prm_sync

// [core/prm_matrix.v]
`timescale 1ns/1ps
`include "prm_map.vh"

module prm_matrix (
    hclk,
    hresetn,
    hsel,
    haddr,
    htrans,
    hwrite,
    hsize,
    hwdata,
    hready,
    hrdata,
    hreadyout,
    hresp,
    stage_start,
    stage_trip,
    remote_block_reset_input,
    start_output_one,
    start_output_two,
    start_output_three,
    trip_output_two,
    aux_output_one,
    aux_output_two
);

// ----------------------------------------------------------------
// ports
// ----------------------------------------------------------------
input wire hclk;
input wire hresetn;
input wire hsel;
input wire [31:0] haddr;
input wire [1:0] htrans;
input wire hwrite;
input wire [2:0] hsize;
input wire [31:0] hwdata;
input wire hready;
output reg [31:0] hrdata;
output reg hreadyout;
output reg hresp;
input wire [3:0] stage_start;
input wire [3:0] stage_trip;
input wire remote_block_reset_input;
output reg start_output_one;
output reg start_output_two;
output reg start_output_three;
output reg trip_output_two;
output reg aux_output_one;
output reg aux_output_two;

// ----------------------------------------------------------------
// declarations
// ----------------------------------------------------------------
reg [7:0] start_trip_route_primary_r;
reg [7:0] trip_route_secondary_r;
reg [7:0] remote_input_config_group_r;
reg wr_pend_r;
reg [7:0] wr_addr_r;
reg [31:0] rd_data_nxt;
reg [31:0] fwd_data;
wire [8:0] pin_raw;
wire [8:0] pin_sync;
wire [3:0] start_s;
wire [3:0] trip_s;
wire block_s;
wire [3:0] stage_block;
wire [3:0] start_live;
wire [3:0] trip_live;
wire [3:0] pri_start_en;
wire [3:0] pri_trip_en;
wire [3:0] sec_two_en;
wire [3:0] sec_three_en;
wire out_one_nxt;
wire out_two_nxt;
wire out_three_nxt;
wire trip_two_nxt;
wire addr_phase;
wire [7:0] addr_lo;
wire fwd_hit;
wire [5:0] out_vec;
wire [`PRM_ST_WIDTH-1:0] status_word;

// ----------------------------------------------------------------
// decoding helpers
// ----------------------------------------------------------------

// true when any routed source is active
function any_routed;
    input [3:0] sig;
    input [3:0] en;
    begin
        any_routed = |(sig & en);
    end
endfunction

// true when the offset names a writable register
function is_rw_reg;
    input [7:0] ofs;
    begin
        is_rw_reg = (ofs == `PRM_OFS_ROUTE_PRI) ||
                    (ofs == `PRM_OFS_ROUTE_SEC) ||
                    (ofs == `PRM_OFS_BLOCK_CFG);
    end
endfunction

// ----------------------------------------------------------------
// pin synchronisation
// ----------------------------------------------------------------

// stage and remote inputs come from outside the clock domain
assign pin_raw = {remote_block_reset_input, stage_trip, stage_start};

prm_sync u_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .async_in(pin_raw),
    .sync_out(pin_sync)
);

assign start_s = pin_sync[3:0];
assign trip_s = pin_sync[7:4];
assign block_s = pin_sync[8];

// ----------------------------------------------------------------
// per-stage blocking and route enables
// ----------------------------------------------------------------
genvar g;
generate
    for (g = 0; g < `PRM_NUM_STAGES; g = g + 1) begin : g_stage
        // remote input silences only the selected stages
        assign stage_block[g] = block_s & remote_input_config_group_r[g];
        assign start_live[g] = start_s[g] & ~stage_block[g];
        assign trip_live[g] = trip_s[g] & ~stage_block[g];
        // even primary bits carry starts, odd primary bits carry trips
        assign pri_start_en[g] = start_trip_route_primary_r[2*g];
        assign pri_trip_en[g] = start_trip_route_primary_r[2*g+1];
        // secondary bits pair each trip to start two or start three
        assign sec_two_en[g] = trip_route_secondary_r[2*g];
        assign sec_three_en[g] = trip_route_secondary_r[2*g+1];
    end
endgenerate

// ----------------------------------------------------------------
// output matrix
// ----------------------------------------------------------------

// wired-or of every enabled source per output
assign out_one_nxt = any_routed(start_live, pri_start_en);
assign trip_two_nxt = any_routed(trip_live, pri_trip_en);
assign out_two_nxt = any_routed(trip_live, sec_two_en);
assign out_three_nxt = any_routed(trip_live, sec_three_en);

// outputs registered; paired outputs share one source term
always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        start_output_one <= 1'b0;
        aux_output_two <= 1'b0;
        trip_output_two <= 1'b0;
        start_output_two <= 1'b0;
        start_output_three <= 1'b0;
        aux_output_one <= 1'b0;
    end else begin
        start_output_one <= out_one_nxt;
        aux_output_two <= out_one_nxt;
        trip_output_two <= trip_two_nxt;
        start_output_two <= out_two_nxt;
        start_output_three <= out_three_nxt;
        aux_output_one <= out_three_nxt;
    end
end

// ----------------------------------------------------------------
// status word
// ----------------------------------------------------------------

// live outputs in a fixed order for read-back
assign out_vec = {aux_output_two, aux_output_one, trip_output_two,
                  start_output_three, start_output_two, start_output_one};

assign status_word = {out_vec, block_s, trip_s, start_s};

// ----------------------------------------------------------------
// ahb-lite address phase
// ----------------------------------------------------------------

// a transfer is taken on nonseq with the bus ready
assign addr_phase = hsel & hready & (htrans == `PRM_HTRANS_NONSEQ);
assign addr_lo = haddr[`PRM_ADDR_BITS-1:0];

// ----------------------------------------------------------------
// read-after-write forwarding
// ----------------------------------------------------------------

// a write lands at the very edge that takes a back-to-back read,
// so the read would otherwise capture the old register value
assign fwd_hit = wr_pend_r & (wr_addr_r == addr_lo);

// the value the pending write is about to store, per register width
always @* begin
    fwd_data = 32'h0000_0000;
    if (wr_addr_r == `PRM_OFS_BLOCK_CFG) begin
        fwd_data[`PRM_BLK_FIELD_MSB:`PRM_BLK_FIELD_LSB] = hwdata[`PRM_BLK_FIELD_MSB:`PRM_BLK_FIELD_LSB];
    end else begin
        fwd_data[7:0] = hwdata[7:0];
    end
end

// read data chosen in the address phase, held in the data phase
always @* begin
    rd_data_nxt = 32'h0000_0000;
    case (addr_lo)
        `PRM_OFS_ROUTE_PRI: begin
            rd_data_nxt[7:0] = start_trip_route_primary_r;
        end
        `PRM_OFS_ROUTE_SEC: begin
            rd_data_nxt[7:0] = trip_route_secondary_r;
        end
        `PRM_OFS_BLOCK_CFG: begin
            rd_data_nxt[7:0] = remote_input_config_group_r;
        end
        `PRM_OFS_STATUS: begin
            rd_data_nxt[`PRM_ST_WIDTH-1:0] = status_word;
        end
        default: begin
            rd_data_nxt = 32'h0000_0000;
        end
    endcase
    // a pending write to the same register wins
    if (fwd_hit) begin
        rd_data_nxt = fwd_data;
    end
end

// capture write target and read data; slave never stalls
always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        wr_pend_r <= 1'b0;
        wr_addr_r <= 8'h00;
        hrdata <= 32'h0000_0000;
        hreadyout <= 1'b1;
        hresp <= `PRM_HRESP_OKAY;
    end else begin
        hreadyout <= 1'b1;
        hresp <= `PRM_HRESP_OKAY;
        wr_pend_r <= addr_phase & hwrite & is_rw_reg(addr_lo);
        if (addr_phase) begin
            wr_addr_r <= addr_lo;
        end
        if (addr_phase & ~hwrite) begin
            hrdata <= rd_data_nxt;
        end
    end
end

// ----------------------------------------------------------------
// ahb-lite data phase: register writes
// ----------------------------------------------------------------

// route switchgroups take low byte of hwdata, block config only bits 3:0; upper bits ignored
always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        start_trip_route_primary_r <= `PRM_RST_ROUTE_PRI;
        trip_route_secondary_r <= `PRM_RST_ROUTE_SEC;
        remote_input_config_group_r <= `PRM_RST_BLOCK_CFG;
    end else if (wr_pend_r) begin
        case (wr_addr_r)
            `PRM_OFS_ROUTE_PRI: begin
                start_trip_route_primary_r <= hwdata[7:0];
            end
            `PRM_OFS_ROUTE_SEC: begin
                trip_route_secondary_r <= hwdata[7:0];
            end
            `PRM_OFS_BLOCK_CFG: begin
                remote_input_config_group_r <= {4'h0, hwdata[`PRM_BLK_FIELD_MSB:`PRM_BLK_FIELD_LSB]};
            end
            default: begin
                remote_input_config_group_r <= remote_input_config_group_r;
            end
        endcase
    end
end

endmodule // prm_matrix

// [sim/prm_stage_model.sv]
`timescale 1ns/1ps

// ----
// stage logic and remote input, as seen by the matrix
// ----
module prm_stage_model (
    input wire hclk,
    input wire hresetn,
    input wire [3:0] start_cmd,
    input wire [3:0] trip_cmd,
    input wire block_cmd,
    output reg [3:0] stage_start,
    output reg [3:0] stage_trip,
    output reg remote_block_reset_input
);
    // stage levels change one edge after the command
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            stage_start <= 4'h0;
            stage_trip <= 4'h0;
            remote_block_reset_input <= 1'b0;
        end else begin
            stage_start <= start_cmd;
            stage_trip <= trip_cmd;
            remote_block_reset_input <= block_cmd;
        end
    end
endmodule // prm_stage_model

// [sim/prm_matrix_properties.sv]
`timescale 1ns/1ps
`include "prm_map.vh"

// ----
// port checker
// ----
module prm_matrix_properties (
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire hready,
    input wire [31:0] hrdata,
    input wire [3:0] stage_start,
    input wire [3:0] stage_trip,
    input wire start_output_one,
    input wire start_output_two,
    input wire start_output_three,
    input wire trip_output_two,
    input wire aux_output_one,
    input wire aux_output_two
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // read address phase taken
    sequence rd_taken;
        hsel && hready && htrans == `PRM_HTRANS_NONSEQ && !hwrite;
    endsequence
    sequence starts_idle;
        (stage_start == 4'h0)[*4];
    endsequence
    sequence trips_idle;
        (stage_trip == 4'h0)[*4];
    endsequence
    chk_pair_start_aux: assert property (start_output_one == aux_output_two)
        else $error("start one and aux two differ");
    chk_pair_three_aux: assert property (start_output_three == aux_output_one)
        else $error("start three and aux one differ");
    chk_idle_start: assert property (starts_idle |-> !start_output_one)
        else $error("start one active without a start");
    chk_idle_trip: assert property (trips_idle |-> !(start_output_two || start_output_three || trip_output_two))
        else $error("trip route active without a trip");
    chk_start_cause: assert property ($rose(start_output_one) |-> $past(stage_start, 3) != 4'h0)
        else $error("start one rose without cause");
    chk_trip_cause: assert property ($rose(trip_output_two) |-> $past(stage_trip, 3) != 4'h0)
        else $error("trip two rose without cause");
    chk_three_cause: assert property ($rose(start_output_three) |-> $past(stage_trip, 3) != 4'h0)
        else $error("start three rose without cause");
    chk_route_width: assert property (rd_taken ##0 (haddr[7:0] < 8'h08) |=> hrdata[31:8] == 24'h0)
        else $error("route register wider than eight bits");
endmodule // prm_matrix_properties

bind prm_matrix prm_matrix_properties u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .stage_start(stage_start),
    .stage_trip(stage_trip), .start_output_one(start_output_one), .start_output_two(start_output_two),
    .start_output_three(start_output_three), .trip_output_two(trip_output_two),
    .aux_output_one(aux_output_one), .aux_output_two(aux_output_two));

// [sim/tb.sv]
`timescale 1ns/1ps
`include "prm_map.vh"

// ----
// bench
// ----
module tb;
    reg hclk = 1'b0;
    reg hresetn = 1'b0;
    reg hsel = 1'b0;
    reg [31:0] haddr = 32'h0;
    reg [1:0] htrans = 2'b00;
    reg hwrite = 1'b0;
    reg [31:0] hwdata = 32'h0;
    reg [3:0] start_cmd = 4'h0;
    reg [3:0] trip_cmd = 4'h0;
    reg block_cmd = 1'b0;
    wire [31:0] hrdata;
    wire hreadyout, hresp, blk, s1, s2, s3, t2, a1, a2;
    wire [3:0] st, tr;
    reg [7:0] pri_r, sec_r, cfg_r;
    reg [31:0] rd;
    integer miscompares = 0, tests_run = 0, b, s, c;

    always #10 hclk = ~hclk;

    prm_matrix u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .stage_start(st), .stage_trip(tr),
        .remote_block_reset_input(blk), .start_output_one(s1), .start_output_two(s2),
        .start_output_three(s3), .trip_output_two(t2), .aux_output_one(a1), .aux_output_two(a2));
    prm_stage_model u_stg (.hclk(hclk), .hresetn(hresetn), .start_cmd(start_cmd), .trip_cmd(trip_cmd),
        .block_cmd(block_cmd), .stage_start(st), .stage_trip(tr), .remote_block_reset_input(blk));

    task compare(input [31:0] got, input [31:0] exp);
        begin
            tests_run = tests_run + 1;
            if (got !== exp) begin
                miscompares = miscompares + 1;
                $display("BAD t=%0t got %h exp %h", $time, got, exp);
            end
        end
    endtask

    // single transfers, held until hready is seen high
    task bus_xfer(input [7:0] a, input wr, input [31:0] d, output [31:0] q);
        begin
            hsel <= 1'b1;
            haddr <= {24'h0, a};
            hwrite <= wr;
            htrans <= `PRM_HTRANS_NONSEQ;
            @(posedge hclk);
            while (!hreadyout) @(posedge hclk);
            htrans <= 2'b00;
            hwdata <= d;
            @(posedge hclk);
            while (!hreadyout) @(posedge hclk);
            q = hrdata;
        end
    endtask

    // expected {aux2, aux1, trip2, start3, start2, start1}
    function [5:0] exp_outs(input [3:0] sv, input [3:0] tv);
        reg [3:0] m, p, q;
        begin
            m = block_cmd ? ~cfg_r[3:0] : 4'hf;
            p = sv & m;
            q = tv & m;
            exp_outs[0] = |(p & {pri_r[6], pri_r[4], pri_r[2], pri_r[0]});
            exp_outs[1] = |(q & {sec_r[6], sec_r[4], sec_r[2], sec_r[0]});
            exp_outs[2] = |(q & {sec_r[7], sec_r[5], sec_r[3], sec_r[1]});
            exp_outs[3] = |(q & {pri_r[7], pri_r[5], pri_r[3], pri_r[1]});
            exp_outs[4] = exp_outs[2];
            exp_outs[5] = exp_outs[0];
        end
    endfunction

    // every single stage signal, then all at once
    task sweep;
        reg [7:0] p;
        begin
            for (s = 0; s < 9; s = s + 1) begin
                p = (s < 8) ? (8'h01 << s) : 8'hff;
                start_cmd <= p[3:0];
                trip_cmd <= p[7:4];
                repeat (6) @(posedge hclk);
                compare({26'h0, a2, a1, t2, s3, s2, s1}, {26'h0, exp_outs(p[3:0], p[7:4])});
            end
            // status read-back with every stage signal active
            bus_xfer(`PRM_OFS_STATUS, 1'b0, 32'h0, rd);
            compare(rd, {17'h0, exp_outs(4'hf, 4'hf), block_cmd, 8'hff});
        end
    endtask

    task set_routes(input [7:0] p, input [7:0] q);
        begin
            pri_r = p;
            sec_r = q;
            bus_xfer(`PRM_OFS_ROUTE_PRI, 1'b1, {24'h0, p}, rd);
            bus_xfer(`PRM_OFS_ROUTE_SEC, 1'b1, {24'h0, q}, rd);
        end
    endtask

    task finish_test;
        begin
            $display("mismatches %0d of %0d comparisons", miscompares, tests_run);
            if (miscompares == 0 && tests_run > 0)
                $display("*** PASS ***");
            else
                $display("*** FAIL ***");
            $finish;
        end
    endtask

    initial begin
        #400000;
        miscompares = miscompares + 1;
        finish_test;
    end

    initial begin
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        bus_xfer(`PRM_OFS_ROUTE_PRI, 1'b0, 32'h0, rd);
        compare(rd, 32'h55);
        bus_xfer(`PRM_OFS_ROUTE_SEC, 1'b0, 32'h0, rd);
        compare(rd, 32'ha5);
        bus_xfer(`PRM_OFS_BLOCK_CFG, 1'b0, 32'h0, rd);
        compare(rd, 32'h0);
        bus_xfer(8'h10, 1'b0, 32'h0, rd);
        compare(rd, 32'h0);
        pri_r = 8'h55;
        sec_r = 8'ha5;
        cfg_r = 8'h00;
        sweep;
        // one routing bit at a time
        for (b = 0; b < 16; b = b + 1) begin
            set_routes((b < 8) ? (8'h01 << b) : 8'h00, (b < 8) ? 8'h00 : (8'h01 << (b - 8)));
            sweep;
        end
        set_routes(8'hff, 8'hff);
        sweep;
        // remote blocking, none then one stage at a time
        block_cmd <= 1'b1;
        for (c = 0; c < 5; c = c + 1) begin
            cfg_r = (c == 0) ? 8'h00 : (8'h01 << (c - 1));
            bus_xfer(`PRM_OFS_BLOCK_CFG, 1'b1, {24'h0, cfg_r}, rd);
            sweep;
        end
        // remote input released: configured stages run again
        block_cmd <= 1'b0;
        sweep;
        bus_xfer(`PRM_OFS_BLOCK_CFG, 1'b1, 32'hff, rd);
        bus_xfer(`PRM_OFS_BLOCK_CFG, 1'b0, 32'h0, rd);
        compare(rd, 32'h0f);
        finish_test;
    end
endmodule // tb
